// ### hdl/dvq_defs.svh
// Offsets, field positions and reset values of the data value qualifier.
`ifndef DVQ_DEFS_SVH
`define DVQ_DEFS_SVH

// Register byte offsets on the APB port.
`define DVQ_OFF_CTRL_ZERO 12'h000
`define DVQ_OFF_CTRL_TWO 12'h004
`define DVQ_OFF_STATUS 12'h008
`define DVQ_OFF_VALUE_ONE 12'h00c
`define DVQ_OFF_VALUE_TWO 12'h010

// Fields of debug_control_zero.
`define DVQ_C0_U1_RD 0
`define DVQ_C0_U1_WR 1
`define DVQ_C0_U2_RD 2
`define DVQ_C0_U2_WR 3
`define DVQ_C0_WIDTH 4

// Fields of debug_control_two.
`define DVQ_C2_U1_BE_LSB 0
`define DVQ_C2_U2_BE_LSB 4
`define DVQ_C2_U1_MODE_LSB 8
`define DVQ_C2_U2_MODE_LSB 10
`define DVQ_C2_ASYNC 12
`define DVQ_C2_WIDTH 13

// Fields of debug_event_status.
`define DVQ_ST_HITS_LSB 0
`define DVQ_ST_IMPRECISE 4
`define DVQ_ST_STOPPED 5

// Compare mode encodings.
`define DVQ_MODE_NONE 2'h0
`define DVQ_MODE_AND 2'h1
`define DVQ_MODE_OR 2'h2
`define DVQ_MODE_ANDOR 2'h3

// Reset values.
`define DVQ_RST_CTRL_ZERO 4'h0
`define DVQ_RST_CTRL_TWO 13'h0000
`define DVQ_RST_VALUE 32'h0000_0000
`define DVQ_RST_HITS 4'h0

`endif

// ### hdl/dvq_pkg.sv
// Types shared by the data value qualifier and its bench.
package dvq_pkg;

   // Storage access kinds reported by the load/store pipeline.
   typedef enum logic [4:0] {
      OP_NONE,
      OP_LOAD,
      OP_STORE,
      OP_STORE_COND,
      OP_STRING_LOAD,
      OP_STRING_STORE,
      OP_BLK_ZERO,
      OP_BLK_INVAL,
      OP_BLK_STORE,
      OP_BLK_FLUSH,
      OP_DTOUCH,
      OP_DTOUCH_ST,
      OP_ITOUCH,
      OP_BLK_ALLOC,
      OP_IBLK_INVAL,
      OP_DCACHE_INVAL_ALL,
      OP_DCACHE_INDEX_READ,
      OP_ICACHE_INVAL_ALL,
      OP_ICACHE_INDEX_READ
   } dvq_op_t;

   // One storage access as seen by the debug logic.
   typedef struct packed {
      logic valid;
      dvq_op_t op;
      logic [31:0] addr;
      logic [2:0] size;
      logic [31:0] data;
      logic [1:0] addr_hit;
      logic caching_inhibited;
      logic storage_fault;
      logic tlb_miss;
      logic reserved_ok;
      logic string_byte_count_zero;
   } dvq_access_t;

   // Run or stop state of the core as steered by debug events.
   typedef enum logic {
      ST_RUN,
      ST_STOP
   } dvq_state_t;

endpackage : dvq_pkg

// ### hdl/dvq_lane_cmp.sv
// Byte lane comparator of one value compare unit.
`timescale 1ns/1ps
`include "dvq_defs.svh"

module dvq_lane_cmp #(
   parameter int LANES = 4
) (
   input wire logic [8*LANES-1:0] value,
   input wire logic [8*LANES-1:0] data,
   input wire logic [LANES-1:0] accessed,
   input wire logic [LANES-1:0] enables,
   input wire logic [1:0] mode,
   output logic match
);

   logic [LANES-1:0] lane_ok;
   logic all_ok;
   logic any_ok;
   logic pair_lo_ok;
   logic pair_hi_ok;

   // A lane matches when it carries data and the byte equals the compare byte; lane 0 is the MSB.
   genvar i;
   generate
      for (i = 0; i < LANES; i++) begin : g_lane
         assign lane_ok[i] = accessed[i] &&
            (data[8*(LANES-1-i) +: 8] == value[8*(LANES-1-i) +: 8]);
      end
   endgenerate

   // Every enabled lane must match, and at least one lane must be enabled.
   assign all_ok = (enables != '0) && (&(~enables | lane_ok));
   assign any_ok = |(enables & lane_ok);
   assign pair_lo_ok = (enables[1:0] != 2'h0) && (&(~enables[1:0] | lane_ok[1:0]));
   assign pair_hi_ok = (enables[3:2] != 2'h0) && (&(~enables[3:2] | lane_ok[3:2]));

   // Mode selects the combination; the undefined encoding never matches.
   always_comb begin
      match = 1'b0;
      unique case (mode)
         `DVQ_MODE_AND: match = all_ok;
         `DVQ_MODE_OR: match = any_ok;
         `DVQ_MODE_ANDOR: match = pair_lo_ok || pair_hi_ok;
         `DVQ_MODE_NONE: match = 1'b0;
      endcase
   end

endmodule : dvq_lane_cmp

// ### hdl/dvq_top.sv
// Data address and data value compare qualifier with its APB register file.
//
// What this block does
// - Block zero and block invalidate count as writes for address compare.
// - Block store and block flush count as writes for address compare.
// - Touches count as reads; touches turned into no-ops raise no event.
// - Block allocate is a no-op and never raises an event.
// - Instruction block invalidate counts as a read.
// - Whole cache invalidates and index reads never raise events.
// - Conditional store without reservation raises no write event.
// - String accesses with zero byte count raise no events.
// - Value events need address conditions met, then a data match.
// - Two independent four byte compare value registers.
// - Value events set the shared read or write status bits.
// - Zero lane enables disable the value event; non-zero enables it.
// - Enable bits 0 to 3 map to lanes 0 to 3, lane 0 MSB.
// - A lane matches only when transferred and equal to the compare byte.
// - Only bytes inside the aligned word of the starting byte count.
// - Mode 01 needs every enabled lane accessed and matching.
// - Mode 10 needs at least one enabled lane accessed and matching.
// - Mode 11 applies the all-lanes test per lane pair, ORed.
// - Value events follow the async handling bit like address events.
// - Every access of a multi-access instruction is judged on its own.
// - Synchronous external or wait mode: record, suppress, stop at instruction.
// - Internal mode with interrupts off: flag imprecise, continue, interrupt later.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "dvq_defs.svh"

module dvq_top #(
   parameter int UNITS = 2,
   parameter int LANES = 4
) (
   input wire logic CLK,
   input wire logic RST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Storage access from the load/store pipeline.
   input wire dvq_pkg::dvq_access_t ACCESS,
   // Debug mode state of the core.
   input wire logic EXT_DEBUG_MODE,
   input wire logic DEBUG_WAIT_MODE,
   input wire logic INT_DEBUG_MODE,
   input wire logic DEBUG_INTERRUPT_ENABLE,
   input wire logic RESUME,
   // Event handling toward the pipeline and debug control.
   output logic [3:0] EVENT_HIT,
   output logic SUPPRESS,
   output logic STOPPED,
   output logic DEBUG_IRQ
);

   // Software visible state.
   logic [`DVQ_C0_WIDTH-1:0] debug_control_zero_q;
   logic [`DVQ_C2_WIDTH-1:0] debug_control_two_q;
   logic [31:0] value_compare_reg_one_q;
   logic [31:0] value_compare_reg_two_q;
   logic [3:0] hits_q;
   logic [3:0] hits_d;
   logic imprecise_event_flag_q;
   logic imprecise_d;
   dvq_pkg::dvq_state_t state_q;

   // Bus side state.
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [3:0] event_hit_q;
   logic suppress_q;
   logic irq_q;

   // Control field views.
   logic [3:0] unit1_lane_enables;
   logic [3:0] unit2_lane_enables;
   logic [1:0] unit1_compare_mode;
   logic [1:0] unit2_compare_mode;
   logic async_event_handling;

   assign unit1_lane_enables = debug_control_two_q[`DVQ_C2_U1_BE_LSB +: 4];
   assign unit2_lane_enables = debug_control_two_q[`DVQ_C2_U2_BE_LSB +: 4];
   assign unit1_compare_mode = debug_control_two_q[`DVQ_C2_U1_MODE_LSB +: 2];
   assign unit2_compare_mode = debug_control_two_q[`DVQ_C2_U2_MODE_LSB +: 2];
   assign async_event_handling = debug_control_two_q[`DVQ_C2_ASYNC];

   // Accesses that count as writes for address compare.
   function automatic logic op_is_write(input dvq_pkg::dvq_op_t op);
      unique case (op)
         dvq_pkg::OP_STORE,
         dvq_pkg::OP_STORE_COND,
         dvq_pkg::OP_STRING_STORE: op_is_write = 1'b1;
         dvq_pkg::OP_BLK_ZERO,
         dvq_pkg::OP_BLK_INVAL: op_is_write = 1'b1;
         dvq_pkg::OP_BLK_STORE,
         dvq_pkg::OP_BLK_FLUSH: op_is_write = 1'b1;
         default: op_is_write = 1'b0;
      endcase
   endfunction : op_is_write

   // Accesses that count as reads; allocate and address-less cache operations are neither.
   function automatic logic op_is_read(input dvq_pkg::dvq_op_t op);
      unique case (op)
         dvq_pkg::OP_LOAD,
         dvq_pkg::OP_STRING_LOAD: op_is_read = 1'b1;
         dvq_pkg::OP_DTOUCH,
         dvq_pkg::OP_DTOUCH_ST,
         dvq_pkg::OP_ITOUCH: op_is_read = 1'b1;
         dvq_pkg::OP_IBLK_INVAL: op_is_read = 1'b1;
         dvq_pkg::OP_BLK_ALLOC: op_is_read = 1'b0;
         dvq_pkg::OP_DCACHE_INVAL_ALL,
         dvq_pkg::OP_DCACHE_INDEX_READ,
         dvq_pkg::OP_ICACHE_INVAL_ALL,
         dvq_pkg::OP_ICACHE_INDEX_READ: op_is_read = 1'b0;
         default: op_is_read = 1'b0;
      endcase
   endfunction : op_is_read

   // Touch operations, which become no-ops on some conditions.
   function automatic logic op_is_touch(input dvq_pkg::dvq_op_t op);
      op_is_touch = (op == dvq_pkg::OP_DTOUCH) || (op == dvq_pkg::OP_DTOUCH_ST) ||
         (op == dvq_pkg::OP_ITOUCH);
   endfunction : op_is_touch

   // Operations that carry data for the value compare.
   function automatic logic op_has_value(input dvq_pkg::dvq_op_t op);
      op_has_value = (op == dvq_pkg::OP_LOAD) || (op == dvq_pkg::OP_STORE) ||
         (op == dvq_pkg::OP_STORE_COND) || (op == dvq_pkg::OP_STRING_LOAD) ||
         (op == dvq_pkg::OP_STRING_STORE) || (op == dvq_pkg::OP_BLK_ZERO);
   endfunction : op_has_value

   // Lanes inside the aligned word of the starting byte; bytes past lane 3 are dropped.
   function automatic logic [3:0] lane_mask(input logic [1:0] off, input logic [2:0] size);
      logic [3:0] m;
      logic [3:0] stop;
      m = 4'h0;
      stop = {2'h0, off} + {1'b0, size};
      for (int i = 0; i < 4; i++) begin
         m[i] = (4'(i) >= {2'h0, off}) && (4'(i) < stop);
      end
      lane_mask = m;
   endfunction : lane_mask

   // Qualification of the present access, judged per access.
   logic acc_blocked;
   logic touch_noop;
   logic acc_rd;
   logic acc_wr;
   logic [3:0] accessed;
   logic [31:0] acc_data;
   logic [UNITS-1:0] value_match;
   logic [3:0] event_now;
   logic any_event;

   // A zero count string transfer or a failed conditional store touches no storage.
   assign acc_blocked = !ACCESS.valid || ACCESS.string_byte_count_zero;
   assign touch_noop = op_is_touch(ACCESS.op) &&
      (ACCESS.caching_inhibited || ACCESS.storage_fault || ACCESS.tlb_miss);
   assign acc_rd = !acc_blocked && op_is_read(ACCESS.op) && !touch_noop;
   assign acc_wr = !acc_blocked && op_is_write(ACCESS.op) &&
      !((ACCESS.op == dvq_pkg::OP_STORE_COND) && !ACCESS.reserved_ok);
   assign accessed = lane_mask(ACCESS.addr[1:0], ACCESS.size);

   // Block zero writes zeros whatever the pipeline shows on its data bus.
   assign acc_data = (ACCESS.op == dvq_pkg::OP_BLK_ZERO) ? 32'h0000_0000 : ACCESS.data;

   // Two independent lane comparators, one per compare value register.
   dvq_lane_cmp #(
      .LANES(LANES)
   ) u_cmp_one (
      .value(value_compare_reg_one_q),
      .data(acc_data),
      .accessed(accessed),
      .enables(unit1_lane_enables),
      .mode(unit1_compare_mode),
      .match(value_match[0])
   );

   dvq_lane_cmp #(
      .LANES(LANES)
   ) u_cmp_two (
      .value(value_compare_reg_two_q),
      .data(acc_data),
      .accessed(accessed),
      .enables(unit2_lane_enables),
      .mode(unit2_compare_mode),
      .match(value_match[1])
   );

   // Per unit events: address compare alone with zero enables, else address plus value.
   always_comb begin
      logic u1_val;
      logic u2_val;
      u1_val = unit1_lane_enables != 4'h0;
      u2_val = unit2_lane_enables != 4'h0;
      event_now[0] = acc_rd && ACCESS.addr_hit[0] && debug_control_zero_q[`DVQ_C0_U1_RD] &&
         (!u1_val || (op_has_value(ACCESS.op) && value_match[0]));
      event_now[1] = acc_wr && ACCESS.addr_hit[0] && debug_control_zero_q[`DVQ_C0_U1_WR] &&
         (!u1_val || (op_has_value(ACCESS.op) && value_match[0]));
      event_now[2] = acc_rd && ACCESS.addr_hit[1] && debug_control_zero_q[`DVQ_C0_U2_RD] &&
         (!u2_val || (op_has_value(ACCESS.op) && value_match[1]));
      event_now[3] = acc_wr && ACCESS.addr_hit[1] && debug_control_zero_q[`DVQ_C0_U2_WR] &&
         (!u2_val || (op_has_value(ACCESS.op) && value_match[1]));
   end

   assign any_event = |event_now;

   // Handling context of an event.
   logic stop_mode;
   logic int_only_off;
   logic do_suppress;
   logic apb_write;
   logic apb_setup;
   logic [3:0] hit_clear;

   assign stop_mode = EXT_DEBUG_MODE || DEBUG_WAIT_MODE;
   assign int_only_off = INT_DEBUG_MODE && !stop_mode && !DEBUG_INTERRUPT_ENABLE;
   // Only synchronous handling holds the instruction back, in stop or interrupt context.
   assign do_suppress = any_event && !async_event_handling &&
      (stop_mode || (INT_DEBUG_MODE && DEBUG_INTERRUPT_ENABLE));

   assign apb_setup = PSEL && !PENABLE;
   assign apb_write = PSEL && PENABLE && PWRITE && pready_q;
   assign hit_clear = (apb_write && (PADDR == `DVQ_OFF_STATUS)) ?
      PWDATA[`DVQ_ST_HITS_LSB +: 4] : 4'h0;

   // Status hit bits are write one to clear; a new event in the same cycle wins.
   assign hits_d = (hits_q & ~hit_clear) | event_now;
   assign imprecise_d = (imprecise_event_flag_q &&
      !(apb_write && (PADDR == `DVQ_OFF_STATUS) && PWDATA[`DVQ_ST_IMPRECISE])) ||
      (any_event && int_only_off);

   // Control registers written by software.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         debug_control_zero_q <= `DVQ_RST_CTRL_ZERO;
         debug_control_two_q <= `DVQ_RST_CTRL_TWO;
         value_compare_reg_one_q <= `DVQ_RST_VALUE;
         value_compare_reg_two_q <= `DVQ_RST_VALUE;
      end else if (apb_write) begin
         unique case (PADDR)
            `DVQ_OFF_CTRL_ZERO: debug_control_zero_q <= PWDATA[`DVQ_C0_WIDTH-1:0];
            `DVQ_OFF_CTRL_TWO: debug_control_two_q <= PWDATA[`DVQ_C2_WIDTH-1:0];
            `DVQ_OFF_VALUE_ONE: value_compare_reg_one_q <= PWDATA;
            `DVQ_OFF_VALUE_TWO: value_compare_reg_two_q <= PWDATA;
            default: ;
         endcase
      end
   end

   // Sticky event status.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         hits_q <= `DVQ_RST_HITS;
         imprecise_event_flag_q <= 1'b0;
      end else begin
         hits_q <= hits_d;
         imprecise_event_flag_q <= imprecise_d;
      end
   end

   // Stop state: entered on any event in external or wait mode, left on resume.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_q <= dvq_pkg::ST_RUN;
      end else begin
         unique case (state_q)
            dvq_pkg::ST_RUN: if (any_event && stop_mode) state_q <= dvq_pkg::ST_STOP;
            dvq_pkg::ST_STOP: if (RESUME) state_q <= dvq_pkg::ST_RUN;
         endcase
      end
   end

   // Event pulses and suppression toward the pipeline.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         event_hit_q <= 4'h0;
         suppress_q <= 1'b0;
      end else begin
         event_hit_q <= event_now;
         suppress_q <= do_suppress;
      end
   end

   // Debug interrupt stands in internal mode outside external or wait mode, while interrupts are on and a hit is still recorded.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= INT_DEBUG_MODE && !stop_mode && DEBUG_INTERRUPT_ENABLE &&
            (hits_d != 4'h0);
      end
   end

   // APB answer: data and error are prepared in setup, ready rises for one access cycle.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= apb_setup;
         if (apb_setup) begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            unique case (PADDR)
               `DVQ_OFF_CTRL_ZERO: prdata_q <= {28'h0, debug_control_zero_q};
               `DVQ_OFF_CTRL_TWO: prdata_q <= {19'h0, debug_control_two_q};
               `DVQ_OFF_STATUS: prdata_q <= {26'h0, state_q == dvq_pkg::ST_STOP,
                  imprecise_event_flag_q, hits_q};
               `DVQ_OFF_VALUE_ONE: prdata_q <= value_compare_reg_one_q;
               `DVQ_OFF_VALUE_TWO: prdata_q <= value_compare_reg_two_q;
               default: pslverr_q <= 1'b1;
            endcase
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign EVENT_HIT = event_hit_q;
   assign SUPPRESS = suppress_q;
   assign STOPPED = state_q == dvq_pkg::ST_STOP;
   assign DEBUG_IRQ = irq_q;

endmodule : dvq_top

// ### test/dvq_pipe_model.sv
// Load/store pipeline stand-in that presents storage accesses to the qualifier.
`timescale 1ns/1ps
module dvq_pipe_model (
   input wire logic CLK,
   output dvq_pkg::dvq_access_t ACCESS
);
   initial ACCESS = '0;

   // Presents one storage access in the cycle after the next edge.
   task automatic put(input dvq_pkg::dvq_access_t x);
      @(posedge CLK);
      ACCESS <= x;
   endtask : put

   // Drops valid and inverts the payload so a stale word never looks current.
   task automatic idle;
      @(posedge CLK);
      ACCESS.valid <= 1'h0;
      ACCESS.data <= ~ACCESS.data;
   endtask : idle
endmodule : dvq_pipe_model

// ### test/dvq_top_chk.sv
// Concurrent checks on the event ports of the data value qualifier.
`timescale 1ns/1ps
module dvq_top_chk (
   input wire logic CLK,
   input wire logic RST,
   input wire dvq_pkg::dvq_access_t ACCESS,
   input wire logic EXT_DEBUG_MODE,
   input wire logic DEBUG_WAIT_MODE,
   input wire logic INT_DEBUG_MODE,
   input wire logic DEBUG_INTERRUPT_ENABLE,
   input wire logic [3:0] EVENT_HIT,
   input wire logic SUPPRESS,
   input wire logic STOPPED,
   input wire logic DEBUG_IRQ
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // Access classes of the current cycle.
   logic v;
   logic wcl;
   logic tch;
   logic dead;
   assign v = ACCESS.valid;
   assign wcl = ACCESS.op inside {dvq_pkg::OP_BLK_ZERO, dvq_pkg::OP_BLK_INVAL,
      dvq_pkg::OP_BLK_STORE, dvq_pkg::OP_BLK_FLUSH};
   assign tch = ACCESS.op inside {dvq_pkg::OP_DTOUCH, dvq_pkg::OP_DTOUCH_ST,
      dvq_pkg::OP_ITOUCH};
   assign dead = ACCESS.op inside {dvq_pkg::OP_BLK_ALLOC, dvq_pkg::OP_DCACHE_INVAL_ALL,
      dvq_pkg::OP_DCACHE_INDEX_READ, dvq_pkg::OP_ICACHE_INVAL_ALL,
      dvq_pkg::OP_ICACHE_INDEX_READ};

   a_write_class_only: assert property (v && wcl |=> !EVENT_HIT[0] && !EVENT_HIT[2])
      else $error("block write op raised a read hit");
   a_read_class_only: assert property (
      v && (tch || ACCESS.op == dvq_pkg::OP_IBLK_INVAL) |=> !EVENT_HIT[1] && !EVENT_HIT[3])
      else $error("read class op raised a write hit");
   a_dead_op_silent: assert property (v && dead |=> EVENT_HIT == 4'h0)
      else $error("op without address raised a hit");
   a_noop_touch_quiet: assert property (
      v && tch && (ACCESS.caching_inhibited || ACCESS.storage_fault || ACCESS.tlb_miss)
      |=> EVENT_HIT == 4'h0)
      else $error("no-op touch raised a hit");
   a_cond_store_gate: assert property (
      v && ACCESS.op == dvq_pkg::OP_STORE_COND && !ACCESS.reserved_ok |=> EVENT_HIT == 4'h0)
      else $error("store without reservation raised a hit");
   a_zero_string: assert property (
      v && ACCESS.string_byte_count_zero && ACCESS.op inside {dvq_pkg::OP_STRING_LOAD,
      dvq_pkg::OP_STRING_STORE} |=> EVENT_HIT == 4'h0)
      else $error("empty string access raised a hit");
   a_hit_needs_addr: assert property (!(v && ACCESS.addr_hit[0]) |=> EVENT_HIT[1:0] == 2'h0)
      else $error("unit one hit without address match");
   a_stop_from_hit: assert property ($rose(STOPPED) |-> EVENT_HIT != 4'h0)
      else $error("stop entered without an event");
   a_ext_hit_stops: assert property (
      |EVENT_HIT && $past(EXT_DEBUG_MODE || DEBUG_WAIT_MODE) |-> STOPPED)
      else $error("event in external mode did not stop");
   a_suppress_cause: assert property (SUPPRESS |-> EVENT_HIT != 4'h0)
      else $error("suppress without an event");
   a_imprecise_runs: assert property (
      |EVENT_HIT && $past(INT_DEBUG_MODE && !DEBUG_INTERRUPT_ENABLE && !EXT_DEBUG_MODE
      && !DEBUG_WAIT_MODE) |-> !SUPPRESS)
      else $error("imprecise event suppressed the access");
   a_irq_needs_de: assert property (
      DEBUG_IRQ |-> $past(INT_DEBUG_MODE && DEBUG_INTERRUPT_ENABLE))
      else $error("interrupt outside internal mode with enable");

   c_sync_stop: cover property (SUPPRESS && STOPPED);
   c_late_irq: cover property (DEBUG_IRQ);
   c_unit_two_write: cover property (EVENT_HIT[3]);
endmodule : dvq_top_chk

// ### test/tb_top.sv
// Self-checking bench for the data value qualifier.
`timescale 1ns/1ps
`include "dvq_defs.svh"
module tb_top;
   logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic EXT, WAITM, INTM, DE, RESUME, SUPPRESS, STOPPED, DEBUG_IRQ, er, sup, stp;
   logic [3:0] EVENT_HIT;
   logic [1:0] c;
   dvq_pkg::dvq_access_t ACCESS, a;
   int err_count, check_count, cycles;

   dvq_top u_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .ACCESS(ACCESS), .EXT_DEBUG_MODE(EXT), .DEBUG_WAIT_MODE(WAITM), .INT_DEBUG_MODE(INTM),
      .DEBUG_INTERRUPT_ENABLE(DE), .RESUME(RESUME), .EVENT_HIT(EVENT_HIT),
      .SUPPRESS(SUPPRESS), .STOPPED(STOPPED), .DEBUG_IRQ(DEBUG_IRQ));
   dvq_pipe_model u_pipe (.CLK(CLK), .ACCESS(ACCESS));

   // Free running core clock.
   initial begin
      CLK = 1'h0;
      forever #25 CLK = ~CLK;
   end

   // Cuts a hung run short.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("Checks made %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // One APB transfer; the request holds until PREADY is seen high.
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'h1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'h1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask : apb

   function automatic dvq_pkg::dvq_access_t mk(input dvq_pkg::dvq_op_t o,
         input logic [1:0] ad, input logic [2:0] sz, input logic [31:0] d, input logic [1:0] h);
      mk = '0;
      mk.valid = 1'h1;
      mk.op = o;
      mk.addr = {30'h0, ad};
      mk.size = sz;
      mk.data = d;
      mk.addr_hit = h;
      mk.reserved_ok = 1'h1;
   endfunction : mk

   // Expected {write, read} class of an access kind for address compare.
   function automatic logic [1:0] cls(input dvq_pkg::dvq_op_t o);
      case (o) inside
         dvq_pkg::OP_LOAD, dvq_pkg::OP_STRING_LOAD, dvq_pkg::OP_DTOUCH, dvq_pkg::OP_DTOUCH_ST,
         dvq_pkg::OP_ITOUCH, dvq_pkg::OP_IBLK_INVAL: cls = 2'h1;
         dvq_pkg::OP_STORE, dvq_pkg::OP_STORE_COND, dvq_pkg::OP_STRING_STORE,
         dvq_pkg::OP_BLK_ZERO, dvq_pkg::OP_BLK_INVAL, dvq_pkg::OP_BLK_STORE,
         dvq_pkg::OP_BLK_FLUSH: cls = 2'h2;
         default: cls = 2'h0;
      endcase
   endfunction : cls

   // Sends one access and compares the event pulse of the following cycle.
   task automatic acc(input dvq_pkg::dvq_access_t x, input logic [3:0] e);
      u_pipe.put(x);
      u_pipe.idle();
      #1;
      sup = SUPPRESS;
      stp = STOPPED;
      chk("event_hit", 32'(EVENT_HIT), 32'(e));
   endtask : acc

   // Programs unit one's value compare and sends a unit one load.
   task automatic vc(input logic [1:0] m, input logic [3:0] be, input logic [1:0] ad,
         input logic [2:0] sz, input logic [31:0] d, input logic [3:0] e);
      apb(1'h1, `DVQ_OFF_CTRL_TWO, {22'h0, m, 4'h0, be});
      acc(mk(dvq_pkg::OP_LOAD, ad, sz, d, 2'h1), e);
   endtask : vc

   task automatic resume;
      @(posedge CLK);
      RESUME <= 1'h1;
      @(posedge CLK);
      RESUME <= 1'h0;
      @(posedge CLK);
      #1;
      chk("stopped_after_resume", 32'(STOPPED), 32'h0);
   endtask : resume

   // Main sequence.
   initial begin
      {err_count, check_count, cycles} = '0;
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      {EXT, WAITM, INTM, DE, RESUME} = '0;
      RST = 1'h1;
      repeat (5) @(posedge CLK);
      RST <= 1'h0;
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, 12'(4 * i), 32'h0);
         chk("reset_value", rd, 32'h0);
      end
      apb(1'h0, 12'h014, 32'h0);
      chk("unmapped_error", 32'(er), 32'h1);
      apb(1'h1, `DVQ_OFF_VALUE_ONE, 32'h11223344);
      apb(1'h1, `DVQ_OFF_VALUE_TWO, 32'ha5b6c7d8);
      apb(1'h1, `DVQ_OFF_CTRL_ZERO, 32'hf);
      apb(1'h0, `DVQ_OFF_VALUE_ONE, 32'h0);
      chk("value_one", rd, 32'h11223344);
      // Every access kind with both address comparators matching.
      for (int i = 0; i < 19; i++) begin
         c = cls(dvq_pkg::dvq_op_t'(i));
         acc(mk(dvq_pkg::dvq_op_t'(i), 2'h0, 3'h4, 32'h0, 2'h3), {c, c});
      end
      for (int j = 0; j < 3; j++) begin
         a = mk(dvq_pkg::OP_DTOUCH, 2'h0, 3'h4, 32'h0, 2'h3);
         {a.caching_inhibited, a.storage_fault, a.tlb_miss} = 3'h4 >> j;
         acc(a, 4'h0);
      end
      a = mk(dvq_pkg::OP_STORE_COND, 2'h0, 3'h4, 32'h0, 2'h3);
      a.reserved_ok = 1'h0;
      acc(a, 4'h0);
      a = mk(dvq_pkg::OP_STRING_STORE, 2'h0, 3'h4, 32'h0, 2'h3);
      a.string_byte_count_zero = 1'h1;
      acc(a, 4'h0);
      vc(`DVQ_MODE_AND, 4'hf, 2'h0, 3'h4, 32'h11223344, 4'h1);
      vc(`DVQ_MODE_AND, 4'hf, 2'h0, 3'h4, 32'h11223345, 4'h0);
      vc(`DVQ_MODE_AND, 4'h3, 2'h0, 3'h2, 32'h11220000, 4'h1);
      vc(`DVQ_MODE_AND, 4'h3, 2'h2, 3'h2, 32'h11223344, 4'h0);
      vc(`DVQ_MODE_AND, 4'hf, 2'h1, 3'h4, 32'h11223344, 4'h0);
      vc(`DVQ_MODE_OR, 4'hf, 2'h3, 3'h1, 32'h00000044, 4'h1);
      vc(`DVQ_MODE_OR, 4'h8, 2'h3, 3'h1, 32'h00000045, 4'h0);
      vc(`DVQ_MODE_ANDOR, 4'hf, 2'h1, 3'h4, 32'h00223344, 4'h1);
      vc(`DVQ_MODE_ANDOR, 4'hf, 2'h0, 3'h4, 32'h11ff33ff, 4'h0);
      vc(`DVQ_MODE_NONE, 4'hf, 2'h0, 3'h4, 32'h11223344, 4'h0);
      vc(`DVQ_MODE_AND, 4'h0, 2'h0, 3'h4, 32'h0, 4'h1);
      // Each access of a burst is judged alone.
      vc(`DVQ_MODE_AND, 4'hf, 2'h0, 3'h4, 32'h0, 4'h0);
      u_pipe.put(mk(dvq_pkg::OP_LOAD, 2'h0, 3'h4, 32'h11223344, 2'h1));
      u_pipe.put(mk(dvq_pkg::OP_LOAD, 2'h0, 3'h4, 32'h11220000, 2'h1));
      #1;
      chk("burst_first", 32'(EVENT_HIT), 32'h1);
      u_pipe.idle();
      #1;
      chk("burst_second", 32'(EVENT_HIT), 32'h0);
      apb(1'h1, `DVQ_OFF_STATUS, 32'h1f);
      apb(1'h1, `DVQ_OFF_CTRL_TWO, {20'h0, `DVQ_MODE_AND, 2'h0, 4'hf, 4'h0});
      acc(mk(dvq_pkg::OP_STORE, 2'h0, 3'h4, 32'ha5b6c7d8, 2'h3), 4'ha);
      apb(1'h0, `DVQ_OFF_STATUS, 32'h0);
      chk("status_hits", rd, 32'ha);
      // Synchronous then asynchronous stop handling.
      apb(1'h1, `DVQ_OFF_CTRL_TWO, 32'h0);
      EXT <= 1'h1;
      acc(mk(dvq_pkg::OP_LOAD, 2'h0, 3'h4, 32'h0, 2'h1), 4'h1);
      chk("suppress", 32'({sup, stp}), 32'h3);
      resume();
      apb(1'h1, `DVQ_OFF_CTRL_TWO, 32'h1000);
      EXT <= 1'h0;
      WAITM <= 1'h1;
      acc(mk(dvq_pkg::OP_LOAD, 2'h0, 3'h4, 32'h0, 2'h1), 4'h1);
      chk("async_stop", 32'({sup, stp}), 32'h1);
      resume();
      // Internal mode with interrupts off, then enabled later.
      apb(1'h1, `DVQ_OFF_CTRL_TWO, 32'h0);
      apb(1'h1, `DVQ_OFF_STATUS, 32'h1f);
      WAITM <= 1'h0;
      INTM <= 1'h1;
      acc(mk(dvq_pkg::OP_LOAD, 2'h0, 3'h4, 32'h0, 2'h1), 4'h1);
      chk("imprecise_run", 32'({sup, stp, DEBUG_IRQ}), 32'h0);
      apb(1'h0, `DVQ_OFF_STATUS, 32'h0);
      chk("imprecise_status", rd, 32'h11);
      DE <= 1'h1;
      repeat (2) @(posedge CLK);
      #1;
      chk("late_irq", 32'(DEBUG_IRQ), 32'h1);
      apb(1'h1, `DVQ_OFF_STATUS, 32'h1f);
      @(posedge CLK);
      #1;
      chk("irq_cleared", 32'(DEBUG_IRQ), 32'h0);
      wrap_up();
   end
endmodule : tb_top

bind dvq_top dvq_top_chk u_chk (.CLK(CLK), .RST(RST), .ACCESS(ACCESS),
   .EXT_DEBUG_MODE(EXT_DEBUG_MODE), .DEBUG_WAIT_MODE(DEBUG_WAIT_MODE),
   .INT_DEBUG_MODE(INT_DEBUG_MODE), .DEBUG_INTERRUPT_ENABLE(DEBUG_INTERRUPT_ENABLE),
   .EVENT_HIT(EVENT_HIT), .SUPPRESS(SUPPRESS), .STOPPED(STOPPED), .DEBUG_IRQ(DEBUG_IRQ));
